/* File: rtl/dim_top.sv */
// dim_top: six digital input measurement channels behind an AXI4-Lite slave.
// assumes raw pins may be asynchronous; all logic on clk at 50 MHz.
// Function
// - level mode reports only the current level of the input selected by srca; scale and the b and index selects ignored.
// - two-signal frequency reports a signed value, sign from rotation direction.
// - quadrature counter counts up or down by phase order of two inputs.
// - up/down counter counts pulses, direction from a static level input.
// - three-signal quadrature counts both ways and accepts an index input.
// - index input marks the zero position of the count.
// - period mode times rising edge to next rising edge.
// - active-time mode times the high level of each pulse.
// - passive-time mode times the low level between pulses.
// - duty-cycle mode reports the high to low time relation.
// - a programmable factor converts pulse time or duty into the value.
// - six channels, each independently configured for any mode.
module dim_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [5:0] din,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [5:0] sync1_q, sync2_q;
    dim_pkg::dim_cfg_t cfg_q [dim_pkg::NCH];
    dim_pkg::dim_cfg_t cfg_d [dim_pkg::NCH];
    logic [5:0] clr_q, clr_d;
    logic [31:0] val [dim_pkg::NCH];
    logic [31:0] raw [dim_pkg::NCH];

    // two stages; only the second is fanned out to the channels
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end else begin
            sync1_q <= din;
            sync2_q <= sync1_q;
        end
    end

    // each channel selects its own a, b and index pins from the six inputs
    generate
        for (genvar i = 0; i < dim_pkg::NCH; i++) begin : g_ch
            dim_pkg::dim_pins_t pins;
            assign pins.a = sync2_q[cfg_q[i].srca[2:0] % 3'h6];
            assign pins.b = sync2_q[cfg_q[i].srcb[2:0] % 3'h6];
            assign pins.c = sync2_q[cfg_q[i].srcc[2:0] % 3'h6];
            dim_channel u_ch (
                .clk(clk),
                .rst_b(rst_b),
                .cfg(cfg_q[i]),
                .pins(pins),
                .clr(clr_q[i]),
                .value_q(val[i]),
                .raw_q(raw[i])
            );
        end
    endgenerate

    // write side: address and data latched independently, either order
    logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_d;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d;
    logic [3:0] ws_q, ws_d;
    logic bad_w;
    logic [1:0] bresp_d;
    logic [2:0] wch;
    logic [7:0] wofs;

    assign wofs = awa_q - dim_pkg::OFS_CFG0;
    assign wch = wofs[6:4];

    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bvalid_d = s_axi_bvalid;
        bresp_d = s_axi_bresp;
        clr_d = 6'h00;
        bad_w = 1'b1;
        for (int k = 0; k < dim_pkg::NCH; k++)
            cfg_d[k] = cfg_q[k];
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_d = 1'b1;
            awa_d = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
            bvalid_d = 1'b0;
        if (aw_have_q && w_have_q && !s_axi_bvalid) begin
            if (awa_q < dim_pkg::OFS_LEVELS && wofs[3:0] == 4'h0
                    && wch < 3'(dim_pkg::NCH)) begin
                bad_w = 1'b0;
                for (int b = 0; b < 4; b++)
                    if (ws_q[b])
                        cfg_d[wch][b*8 +: 8] = wd_q[b*8 +: 8];
            end else if (awa_q == dim_pkg::OFS_CLR) begin
                bad_w = 1'b0;
                if (ws_q[0])
                    clr_d = wd_q[5:0];
            end
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = bad_w ? dim_pkg::RESP_SLVERR : dim_pkg::RESP_OKAY;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0;
            ws_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            clr_q <= 6'h00;
            for (int k = 0; k < dim_pkg::NCH; k++)
                cfg_q[k] <= dim_pkg::CFG_RST;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            // no new write is taken until the pending response is collected
            s_axi_awready <= !aw_have_d && !bvalid_d && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_have_d && !bvalid_d && !(s_axi_wvalid && s_axi_wready);
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp <= bresp_d;
            clr_q <= clr_d;
            for (int k = 0; k < dim_pkg::NCH; k++)
                cfg_q[k] <= cfg_d[k];
        end
    end

    // read side: one outstanding read, answered the cycle after arready
    logic rvalid_d, arready_d;
    logic [31:0] rdata_d;
    logic [1:0] rresp_d;
    logic [7:0] ra, rofs;
    logic [2:0] rch;

    assign ra = s_axi_araddr[7:0];
    assign rofs = ra - dim_pkg::OFS_CFG0;
    assign rch = rofs[6:4];

    always_comb begin
        rvalid_d = s_axi_rvalid;
        rdata_d = s_axi_rdata;
        rresp_d = s_axi_rresp;
        arready_d = !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = dim_pkg::RESP_OKAY;
            rdata_d = 32'h0;
            arready_d = 1'b0;
            if (ra < dim_pkg::OFS_LEVELS && rch < 3'(dim_pkg::NCH)) begin
                unique case (rofs[3:2])
                    2'h0: rdata_d = cfg_q[rch];
                    2'h1: rdata_d = val[rch];
                    2'h2: rdata_d = raw[rch];
                    2'h3: rdata_d = {26'h0, sync2_q};
                endcase
            end else if (ra == dim_pkg::OFS_LEVELS) begin
                rdata_d = {26'h0, sync2_q};
            end else if (ra == dim_pkg::OFS_CLR) begin
                rdata_d = 32'h0;
            end else begin
                rresp_d = dim_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= arready_d;
            s_axi_rvalid <= rvalid_d;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rresp_d;
        end
    end
endmodule // dim_top

/* File: rtl/dim_pkg.sv */
// dim_pkg: register map, field layout, mode codes and carrier types for the
// digital input measurement block.
// assumes one 50 MHz clock and an AXI4-Lite master on the register side.
package dim_pkg;
    localparam int NCH = 6;
    localparam int CLK_HZ = 50000000;
    localparam logic [7:0] OFS_CFG0 = 8'h00;
    localparam logic [7:0] OFS_STRIDE = 8'h10;
    localparam logic [7:0] OFS_LEVELS = 8'h80;
    localparam logic [7:0] OFS_CLR = 8'h84;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_SRCB_LSB = 4;
    localparam int CFG_SRCC_LSB = 8;
    localparam int CFG_SRCA_LSB = 12;
    localparam int CFG_SCALE_LSB = 16;
    localparam logic [31:0] CFG_RST = 32'h0001_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        DIM_MODE_LEVEL = 4'h0,
        DIM_MODE_FREQ = 4'h1,
        DIM_MODE_FREQ2 = 4'h2,
        DIM_MODE_CNT = 4'h3,
        DIM_MODE_UPDN = 4'h4,
        DIM_MODE_QUAD = 4'h5,
        DIM_MODE_QUADIDX = 4'h6,
        DIM_MODE_PERIOD = 4'h7,
        DIM_MODE_HIGH = 4'h8,
        DIM_MODE_LOW = 4'h9,
        DIM_MODE_DUTY = 4'hA
    } dim_mode_t;

    typedef struct packed {
        logic [15:0] scale;
        logic [3:0] srca;
        logic [3:0] srcc;
        logic [3:0] srcb;
        logic [3:0] mode;
    } dim_cfg_t;

    typedef struct packed {
        logic a;
        logic b;
        logic c;
    } dim_pins_t;
endpackage

/* File: rtl/dim_channel.sv */
// dim_channel: one measurement channel; counts, times and scales.
// assumes its pins are already synchronised and cfg is stable while used.
module dim_channel (
    input wire logic clk,
    input wire logic rst_b,
    input wire dim_pkg::dim_cfg_t cfg,
    input wire dim_pkg::dim_pins_t pins,
    input wire logic clr,
    output logic [31:0] value_q,
    output logic [31:0] raw_q
);
    dim_pkg::dim_pins_t prev_q;
    logic [31:0] cnt_q, cnt_d;
    logic [31:0] hi_q, hi_d, lo_q, lo_d, per_q, per_d;
    logic [31:0] last_hi_q, last_hi_d, last_lo_q, last_lo_d;
    logic [31:0] value_d, raw_d;
    logic rise_a, fall_a, rise_c, step, up;
    logic [47:0] prod;
    logic [15:0] hi_sat;

    assign rise_a = pins.a & ~prev_q.a;
    assign fall_a = ~pins.a & prev_q.a;
    assign rise_c = pins.c & ~prev_q.c;
    // high time saturates at 16 bits so the 16.16 quotient always fits
    assign hi_sat = (last_hi_q[31:16] == 16'h0) ? last_hi_q[15:0] : 16'hFFFF;

    always_comb begin
        step = 1'b0;
        up = 1'b1;
        unique case (cfg.mode)
            dim_pkg::DIM_MODE_UPDN: begin
                step = rise_a;
                up = ~pins.b;
            end
            dim_pkg::DIM_MODE_QUAD, dim_pkg::DIM_MODE_QUADIDX, dim_pkg::DIM_MODE_FREQ2: begin
                // x1 decode on a rising: b low means a leads
                step = rise_a;
                up = ~pins.b;
            end
            default: begin
                step = rise_a;
                up = 1'b1;
            end
        endcase
    end

    always_comb begin
        cnt_d = cnt_q;
        hi_d = hi_q;
        lo_d = lo_q;
        per_d = per_q;
        last_hi_d = last_hi_q;
        last_lo_d = last_lo_q;
        if (step) begin
            cnt_d = up ? cnt_q + 32'h1 : cnt_q - 32'h1;
        end
        if (cfg.mode == dim_pkg::DIM_MODE_QUADIDX && rise_c)
            cnt_d = 32'h0;
        if (pins.a)
            hi_d = hi_q + 32'h1;
        else
            lo_d = lo_q + 32'h1;
        per_d = per_q + 32'h1;
        if (fall_a) begin
            last_hi_d = hi_q;
            lo_d = 32'h1;
        end
        if (rise_a) begin
            last_lo_d = lo_q;
            hi_d = 32'h1;
            per_d = 32'h1;
        end
        if (clr) begin
            cnt_d = 32'h0;
            per_d = 32'h0;
            hi_d = 32'h0;
            lo_d = 32'h0;
            last_hi_d = 32'h0;
            last_lo_d = 32'h0;
        end
    end

    // raw reading; frequency modes report the last period in clocks, the two-signal
    // mode with the sign of the direction, so software takes clk_hz / period.
    always_comb begin
        raw_d = raw_q;
        unique case (cfg.mode)
            dim_pkg::DIM_MODE_LEVEL: raw_d = {31'h0, pins.a};
            dim_pkg::DIM_MODE_FREQ, dim_pkg::DIM_MODE_PERIOD: begin
                if (rise_a) raw_d = per_q;
            end
            dim_pkg::DIM_MODE_FREQ2: begin
                if (rise_a) raw_d = ~pins.b ? per_q : 32'h0 - per_q;
            end
            dim_pkg::DIM_MODE_HIGH: raw_d = last_hi_q;
            dim_pkg::DIM_MODE_LOW: raw_d = last_lo_q;
            dim_pkg::DIM_MODE_DUTY: begin
                // high over low time in 16.16; a missing low phase reads as all
                // ones instead of dividing by zero
                raw_d = (last_lo_q == 32'h0) ? 32'hFFFF_FFFF :
                    ({hi_sat, 16'h0} / last_lo_q);
            end
            default: raw_d = cnt_q;
        endcase
    end

    assign prod = 48'(raw_q) * 48'(cfg.scale);
    always_comb begin
        value_d = raw_q;
        if (cfg.mode >= dim_pkg::DIM_MODE_PERIOD)
            value_d = prod[39:8];                       // 8.8 fixed factor
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= '0;
            cnt_q <= 32'h0;
            hi_q <= 32'h0;
            lo_q <= 32'h0;
            per_q <= 32'h0;
            last_hi_q <= 32'h0;
            last_lo_q <= 32'h0;
            raw_q <= 32'h0;
            value_q <= 32'h0;
        end else begin
            prev_q <= pins;
            cnt_q <= cnt_d;
            hi_q <= hi_d;
            lo_q <= lo_d;
            per_q <= per_d;
            last_hi_q <= last_hi_d;
            last_lo_q <= last_lo_d;
            raw_q <= raw_d;
            value_q <= value_d;
        end
    end
endmodule // dim_channel

/* File: tb/dim_top_props.sv */
// dim_top_props: bus handshake and input sampling checks on the dim_top ports.
// assumes a single clk domain and asynchronous active-low rst_b.
module dim_top_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [5:0] din,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [5:0] din_q;
    logic [2:0] st_q;
    logic lvl_q;
    // a level read only means something once din has settled past the sync flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            din_q <= 6'h00;
            st_q <= 3'h0;
            lvl_q <= 1'b0;
        end else begin
            din_q <= din;
            st_q <= (din != din_q) ? 3'h0 : ((st_q == 3'h7) ? 3'h7 : st_q + 3'h1);
            lvl_q <= s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == dim_pkg::OFS_LEVELS;
        end
    end
    AST_LEVELS_SYNC: assert property (lvl_q && st_q >= 3'h4 |-> s_axi_rdata[5:0] == din)
        else $error("level read does not match settled inputs");
    AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response changed before taken");
    AST_B_AFTER_WR: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while read pending");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == dim_pkg::RESP_SLVERR |->
        s_axi_rdata == 32'h0000_0000) else $error("error read carries data");
    AST_RESP_CODE: assert property (s_axi_bvalid |-> s_axi_bresp == dim_pkg::RESP_OKAY ||
        s_axi_bresp == dim_pkg::RESP_SLVERR) else $error("illegal write response code");
endmodule // dim_top_props

/* File: tb/dim_enc_model.sv */
// dim_enc_model: pulse source and two-phase encoder on din[1:0].
// assumes run is held for whole periods of 12 clocks; parks at phase 0 when idle.
module dim_enc_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic rev,
    output logic a,
    output logic b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ph_q;
    logic [3:0] ph_d;
    logic [1:0] q;
    always_comb begin
        ph_d = run ? ((ph_q == 4'hB) ? 4'h0 : ph_q + 4'h1) : 4'h0;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) ph_q <= 4'h0;
        else ph_q <= ph_d;
    end
    assign q = 2'(ph_q / 4'h3);
    // forward: b lags a by a quarter period, reverse: b leads
    assign a = rev ? q[1] : ^q;
    assign b = rev ? ^q : q[1];
endmodule // dim_enc_model

/* File: tb/tb_digital_input_measurement.sv */
// tb_digital_input_measurement: table-driven mode checks plus reset, error and index cases.
// assumes dim_top with an encoder model on din[1:0]; din[5:2] driven here.
module tb_digital_input_measurement;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [2:0] ch; logic [31:0] cfg; logic rev; logic lvl; logic [31:0] ex;} dim_row_t;
    logic clk = 1'b0, rst_b = 1'b0, run = 1'b0, rev = 1'b0, a, b;
    logic [3:0] ext_q = 4'h0;
    logic [5:0] din;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [7:0] base;
    int error_cnt = 0, tests_run = 0;
    dim_row_t rows [15] = '{
        '{3'h0, 32'h0300_3210, 1'b0, 1'b1, 32'h0000_0001}, '{3'h1, 32'h0100_0211, 1'b0, 1'b0, 32'h0000_000C},
        '{3'h2, 32'h0100_0212, 1'b0, 1'b0, 32'h0000_000C}, '{3'h3, 32'h0100_0212, 1'b1, 1'b0, 32'hFFFF_FFF4},
        '{3'h4, 32'h0100_0213, 1'b0, 1'b0, 32'h0000_0003}, '{3'h5, 32'h0100_0234, 1'b0, 1'b1, 32'hFFFF_FFFD},
        '{3'h0, 32'h0100_0234, 1'b0, 1'b0, 32'h0000_0003}, '{3'h1, 32'h0100_0215, 1'b0, 1'b0, 32'h0000_0003},
        '{3'h2, 32'h0100_0215, 1'b1, 1'b0, 32'hFFFF_FFFD}, '{3'h3, 32'h0100_0217, 1'b0, 1'b0, 32'h0000_000C},
        '{3'h4, 32'h0200_0217, 1'b0, 1'b0, 32'h0000_0018}, '{3'h5, 32'h0100_0218, 1'b0, 1'b0, 32'h0000_0006},
        '{3'h0, 32'h0080_0218, 1'b0, 1'b0, 32'h0000_0003}, '{3'h1, 32'h0100_0219, 1'b0, 1'b0, 32'h0000_0006},
        '{3'h2, 32'h0100_021A, 1'b0, 1'b0, 32'h0001_0000}};
    assign din = {ext_q, b, a};
    always #10 clk = ~clk;
    dim_enc_model u_enc (.clk(clk), .rst_b(rst_b), .run(run), .rev(rev), .a(a), .b(b));
    dim_top uut (.clk(clk), .rst_b(rst_b), .din(din), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task automatic test_done;
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] ex);
        tests_run++;
        if (got !== ex) begin
            error_cnt++;
            $display("[FAIL] %0t word %h expected %h", $time, got, ex);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] ex);
        tests_run++;
        if (got !== ex) begin
            error_cnt++;
            $display("[FAIL] %0t response %h expected %h", $time, got, ex);
        end
    endtask
    // address and data offered together, each released on its own handshake
    task automatic axw(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
        bit aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        awaddr <= {24'h00_0000, ad};
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
        @(posedge clk);
        araddr <= {24'h00_0000, ad};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        dt = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // whole 12-clock periods, then let the sync flops and results settle
    task automatic pulses(input int k);
        @(posedge clk);
        run <= 1'b1;
        repeat (12 * k) @(posedge clk);
        run <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 15; i++) begin
            base = {1'b0, rows[i].ch, 4'h0};
            rev <= rows[i].rev;
            ext_q[1] <= rows[i].lvl;
            axw(base, rows[i].cfg, r);
            axw(dim_pkg::OFS_CLR, 32'h1 << rows[i].ch, r);
            pulses(3);
            axr(base + 8'h04, d, r);
            chk_word(d, rows[i].ex);
        end
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        axr(8'h30, d, r);
        chk_word(d, dim_pkg::CFG_RST);
        axr(8'h88, d, r);
        chk_resp(r, dim_pkg::RESP_SLVERR);
        axw(8'h90, 32'h0000_0001, r);
        chk_resp(r, dim_pkg::RESP_SLVERR);
        axw(8'h00, 32'h0100_0416, r);
        pulses(3);
        axr(8'h04, d, r);
        chk_word(d, 32'h0000_0003);
        ext_q[2] <= 1'b1;
        repeat (4) @(posedge clk);
        ext_q[2] <= 1'b0;
        repeat (4) @(posedge clk);
        axr(8'h04, d, r);
        chk_word(d, 32'h0000_0000);
        pulses(2);
        axr(8'h04, d, r);
        chk_word(d, 32'h0000_0002);
        ext_q <= 4'hA;
        repeat (8) @(posedge clk);
        axr(dim_pkg::OFS_LEVELS, d, r);
        chk_word(d, 32'h0000_0028);
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done();
    end
endmodule // tb_digital_input_measurement
bind dim_top dim_top_props u_props (.clk(clk), .rst_b(rst_b), .din(din),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
